// ===== src/frame_tally_chunk_append.sv
// Function
// - chunk kind enable writes are refused unless chunk append is on
// - switching chunk append off clears every chunk kind enable
// - payload kind reports chunk data while chunk append is on
// - an enabled frame tally chunk is appended after the image as trailing words
// - frame tally is 32 bits, starts at zero, adds one per frame
// - tally wraps from all ones to zero and keeps counting
// - stopped continuous acquisition may leave gaps in tally values
// - picking frame tally kind and enabling it appends tally each image
// - tally is zero after power-up reset
// - clear origin: software, line one, line two or off blocks clears
// - clear origin defaults to off after power-up
// - software origin clears tally on the clear command
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "frame_tally_map.svh"
module frame_tally_chunk_append (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frameBegin,
    input wire logic inputLineOne,
    input wire logic inputLineTwo,
    input wire logic [31:0] imgData,
    input wire logic imgValid,
    input wire logic imgLast,
    output logic imgReady,
    output frame_tally_pkg::stream_word_t outWord,
    output logic outValid,
    input wire logic outReady,
    output frame_tally_pkg::payload_kind_t payloadKind
);
    // ==========================================
    // bus access
    logic wrEn;
    logic hit;
    assign wrEn = psel & penable & pwrite;
    assign pready = 1'b1;
    assign hit = (paddr == `REG_CHUNK_CTRL) || (paddr == `REG_CHUNK_KIND)
        || (paddr == `REG_COUNTER_CTRL) || (paddr == `REG_CLEAR_CMD)
        || (paddr == `REG_FRAME_TALLY) || (paddr == `REG_STATUS);
    assign pslverr = psel & penable & ~hit;

    // ==========================================
    // configuration
    logic chunkAppendOn_q;
    frame_tally_pkg::chunk_kind_t chunkKindPick_q;
    logic [`KIND_COUNT-1:0] chunkKindOn_q;
    frame_tally_pkg::clear_origin_t clearOrigin_q;
    logic slotPick_q;
    logic eventOrigin_q;
    logic swClear;
    logic [31:0] tally;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chunkAppendOn_q <= 1'b0;
        end else if (wrEn && paddr == `REG_CHUNK_CTRL) begin
            chunkAppendOn_q <= pwdata[`CHUNK_ON_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chunkKindPick_q <= frame_tally_pkg::KIND_FRAME_TALLY;
        end else if (wrEn && paddr == `REG_CHUNK_KIND) begin
            chunkKindPick_q <= frame_tally_pkg::chunk_kind_t'(pwdata[0]);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chunkKindOn_q <= '0;
        end else if (wrEn && paddr == `REG_CHUNK_CTRL && !pwdata[`CHUNK_ON_BIT]) begin
            chunkKindOn_q <= '0;
        end else if (wrEn && paddr == `REG_CHUNK_KIND) begin
            if (chunkAppendOn_q || !pwdata[`KIND_ON_BIT]) begin
                chunkKindOn_q[pwdata[0]] <= pwdata[`KIND_ON_BIT];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clearOrigin_q <= frame_tally_pkg::CLR_OFF;
            slotPick_q <= 1'b0;
            eventOrigin_q <= 1'b0;
        end else if (wrEn && paddr == `REG_COUNTER_CTRL) begin
            clearOrigin_q <= frame_tally_pkg::clear_origin_t'(pwdata[`ORIGIN_LSB +: 2]);
            slotPick_q <= pwdata[`SLOT_BIT];
            eventOrigin_q <= pwdata[`EVENT_BIT];
        end
    end

    assign swClear = wrEn && (paddr == `REG_CLEAR_CMD) && pwdata[`CLEAR_BIT];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == `REG_CHUNK_CTRL) begin
                prdata <= {31'h0, chunkAppendOn_q};
            end else if (paddr == `REG_CHUNK_KIND) begin
                prdata <= {23'h0, chunkKindOn_q[chunkKindPick_q], 7'h0, chunkKindPick_q};
            end else if (paddr == `REG_COUNTER_CTRL) begin
                prdata <= {23'h0, eventOrigin_q, 3'h0, slotPick_q, 2'h0, clearOrigin_q};
            end else if (paddr == `REG_FRAME_TALLY) begin
                prdata <= tally;
            end else if (paddr == `REG_STATUS) begin
                prdata <= {30'h0, chunkKindOn_q};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ==========================================
    // frame tally and clear sources
    logic riseOne;
    logic riseTwo;
    logic doClear;
    rise_sync u_syncOne (
        .clk(clk),
        .rst(rst),
        .din(inputLineOne),
        .rise(riseOne)
    );
    rise_sync u_syncTwo (
        .clk(clk),
        .rst(rst),
        .din(inputLineTwo),
        .rise(riseTwo)
    );

    always_comb begin
        case (clearOrigin_q)
            frame_tally_pkg::CLR_SOFTWARE: doClear = swClear;
            frame_tally_pkg::CLR_LINE_ONE: doClear = riseOne;
            frame_tally_pkg::CLR_LINE_TWO: doClear = riseTwo;
            default: doClear = 1'b0;
        endcase
    end

    // zero at reset, +1 per frame begin, wraps naturally
    tally_counter #(
        .WIDTH(32)
    ) u_tally (
        .clk(clk),
        .rst(rst),
        .clear(doClear),
        .step(frameBegin),
        .count(tally)
    );

    // ==========================================
    // image pass-through and chunk append
    typedef enum {
        ST_IMAGE,
        ST_CHUNK
    } state_t;
    state_t state_q;
    logic [31:0] snap_q;
    logic [0:0] word_q;
    logic takeImg;
    logic appendTally;

    assign payloadKind = chunkAppendOn_q ? frame_tally_pkg::PAYLOAD_CHUNK
        : frame_tally_pkg::PAYLOAD_IMAGE;
    assign appendTally = chunkAppendOn_q && chunkKindOn_q[frame_tally_pkg::KIND_FRAME_TALLY];
    assign imgReady = (state_q == ST_IMAGE) && (!outValid || outReady);
    assign takeImg = imgValid && imgReady;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            snap_q <= '0;
        end else if (frameBegin) begin
            snap_q <= tally;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IMAGE;
            word_q <= 1'b0;
            outValid <= 1'b0;
            outWord <= '0;
        end else begin
            case (state_q)
                ST_IMAGE: begin
                    if (takeImg) begin
                        outValid <= 1'b1;
                        outWord <= '{data: imgData, last: imgLast && !appendTally,
                            isChunk: 1'b0};
                        if (imgLast && appendTally) begin
                            state_q <= ST_CHUNK;
                            word_q <= 1'b0;
                        end
                    end else if (outReady) begin
                        outValid <= 1'b0;
                    end
                end
                ST_CHUNK: begin
                    if (outReady) begin
                        outValid <= 1'b1;
                        if (word_q == 1'b0) begin
                            outWord <= '{data: `CHUNK_TAG_TALLY, last: 1'b0, isChunk: 1'b1};
                            word_q <= 1'b1;
                        end else begin
                            outWord <= '{data: snap_q, last: 1'b1, isChunk: 1'b1};
                            state_q <= ST_IMAGE;
                        end
                    end
                end
                default: state_q <= ST_IMAGE;
            endcase
        end
    end
endmodule : frame_tally_chunk_append
`default_nettype wire

// ===== src/frame_tally_map.svh
`ifndef FRAME_TALLY_MAP_SVH
`define FRAME_TALLY_MAP_SVH
// ==========================================
// register byte offsets
`define REG_CHUNK_CTRL 12'h000
`define REG_CHUNK_KIND 12'h004
`define REG_COUNTER_CTRL 12'h008
`define REG_CLEAR_CMD 12'h00C
`define REG_FRAME_TALLY 12'h010
`define REG_STATUS 12'h014
// ==========================================
// field positions
`define CHUNK_ON_BIT 0
`define KIND_ON_BIT 8
`define ORIGIN_LSB 0
`define SLOT_BIT 4
`define EVENT_BIT 8
`define CLEAR_BIT 0
`define KIND_COUNT 2
// ==========================================
// reset values
`define TALLY_RESET 32'h0000_0000
// ==========================================
// chunk words appended per image
`define CHUNK_WORDS 2
`define CHUNK_TAG_TALLY 32'h0000_0001
`endif

// ===== src/frame_tally_pkg.sv
package frame_tally_pkg;
    // ==========================================
    // clear origins
    typedef enum logic [1:0] {
        CLR_OFF,
        CLR_SOFTWARE,
        CLR_LINE_ONE,
        CLR_LINE_TWO
    } clear_origin_t;
    // ==========================================
    // chunk kinds
    typedef enum logic [0:0] {
        KIND_FRAME_TALLY,
        KIND_SPARE
    } chunk_kind_t;
    // ==========================================
    // payload kind
    typedef enum logic {
        PAYLOAD_IMAGE,
        PAYLOAD_CHUNK
    } payload_kind_t;
    // ==========================================
    // outgoing word
    typedef struct packed {
        logic [31:0] data;
        logic last;
        logic isChunk;
    } stream_word_t;
endpackage : frame_tally_pkg

// ===== src/rise_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// two-flop synchroniser with rising-edge pulse
module rise_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    output logic rise
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end
    assign rise = sync_q & ~prev_q;
endmodule : rise_sync
`default_nettype wire

// ===== src/tally_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "frame_tally_map.svh"
// ==========================================
// wrapping up-counter with clear
module tally_counter #(
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic step,
    output logic [WIDTH-1:0] count
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= WIDTH'(`TALLY_RESET);
        end else if (clear) begin
            count <= '0;
        end else if (step) begin
            count <= count + WIDTH'(1);
        end
    end
endmodule : tally_counter
`default_nettype wire

// ===== sim/frame_tally_chunk_append_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "frame_tally_map.svh"
// ==========================================
// port checker
module frame_tally_chunk_append_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic imgReady,
    input wire frame_tally_pkg::stream_word_t outWord,
    input wire logic outValid,
    input wire logic outReady,
    input wire frame_tally_pkg::payload_kind_t payloadKind
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic rdAcc = psel && penable && !pwrite;
    logic kindPrev_q;
    wire logic off2 = payloadKind == 1'b0 && kindPrev_q == 1'b0;
    // ==========================================
    // payload kind one cycle back
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            kindPrev_q <= 1'b0;
        end else begin
            kindPrev_q <= payloadKind;
        end
    end
    a_reset_state: assert property (
        $fell(rst) |-> !outValid && payloadKind == 1'b0) else $error("reset state wrong");
    a_payload_kind: assert property (
        psel && penable && pwrite && paddr == `REG_CHUNK_CTRL
        |=> payloadKind == $past(pwdata[0])) else $error("payload kind wrong");
    a_chunk_needs_on: assert property (
        outValid && outWord.isChunk |-> payloadKind == 1'b1) else $error("chunk while off");
    a_kind_refused: assert property (
        rdAcc && paddr == `REG_CHUNK_KIND && off2 |-> !prdata[8]) else $error("kind on");
    a_off_clears_kinds: assert property (
        rdAcc && paddr == `REG_STATUS && off2 |-> prdata[1:0] == 2'h0) else $error("kinds on");
    a_tag_then_tally: assert property (
        outValid && outReady && outWord.isChunk && !outWord.last
        |-> outWord.data == `CHUNK_TAG_TALLY ##[1:16] (outValid && outWord.last))
        else $error("chunk sequence wrong");
    a_word_holds: assert property (
        outValid && !outReady |=> outValid && $stable(outWord)) else $error("word dropped");
    a_image_stalls: assert property (
        outValid && outWord.isChunk && !outWord.last |-> !imgReady)
        else $error("image taken in chunk");
endmodule : frame_tally_chunk_append_sva
bind frame_tally_chunk_append frame_tally_chunk_append_sva frame_tally_chunk_append_sva_i (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .imgReady,
    .outWord, .outValid, .outReady, .payloadKind);
`default_nettype wire

// ===== sim/host_sink.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// host receiving image and chunk words
module host_sink (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire frame_tally_pkg::stream_word_t outWord,
    input wire logic outValid,
    output logic outReady
);
    frame_tally_pkg::stream_word_t got[$];
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            outReady <= 1'b0;
        end else begin
            outReady <= slow ? !outReady : 1'b1;
            if (outValid && outReady) begin
                got.push_back(outWord);
            end
        end
    end
endmodule : host_sink
`default_nettype wire

// ===== sim/frame_tally_chunk_append_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "frame_tally_map.svh"
module frame_tally_chunk_append_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, imgData = 32'h0, prdata, rd;
    logic pready, pslverr, imgReady, outValid, outReady, imgValid = 1'b0, imgLast = 1'b0;
    logic frameBegin = 1'b0, inputLineOne = 1'b0, inputLineTwo = 1'b0, slow = 1'b0;
    frame_tally_pkg::stream_word_t outWord;
    frame_tally_pkg::payload_kind_t payloadKind;
    int nErrors = 0, testsRun = 0;
    always #2.5 clk = ~clk;
    frame_tally_chunk_append frame_tally_chunk_append_i (.clk, .rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .frameBegin, .inputLineOne,
        .inputLineTwo, .imgData, .imgValid, .imgLast, .imgReady, .outWord, .outValid,
        .outReady, .payloadKind);
    host_sink host_sink_i (.clk, .rst, .slow, .outWord, .outValid, .outReady);
    // ==========================================
    // shared tasks
    task automatic conclude;
        if (nErrors == 0 && testsRun > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        testsRun++;
        if (got !== exp) begin
            nErrors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic frames(input int n);
        repeat (n) begin
            @(posedge clk);
            frameBegin <= 1'b1;
            @(posedge clk);
            frameBegin <= 1'b0;
        end
    endtask : frames
    task automatic send(input logic [31:0] d, input logic l);
        @(posedge clk);
        imgValid <= 1'b1;
        imgData <= d;
        imgLast <= l;
        @(posedge clk);
        while (imgReady !== 1'b1) @(posedge clk);
        imgValid <= 1'b0;
    endtask : send
    // ==========================================
    // scenarios
    task automatic t_defaults;
        apb(0, `REG_FRAME_TALLY, 0);
        chk(rd, 0);
        apb(0, `REG_COUNTER_CTRL, 0);
        chk(rd, 0);
        apb(1, `REG_CHUNK_KIND, 32'h0000_0100);
        apb(0, `REG_CHUNK_KIND, 0);
        chk(rd[8], 0);
        @(negedge clk);
        chk(payloadKind, 0);
        apb(0, 12'h020, 0);
        chk({err, rd}, 33'h1_0000_0000);
    endtask : t_defaults
    task automatic t_chunk;
        logic [33:0] ex[4] = '{{32'hA5A5_0001, 2'h0}, {32'h5A5A_0002, 2'h0},
            {`CHUNK_TAG_TALLY, 2'h1}, {32'h0000_0002, 2'h3}};
        apb(1, `REG_CHUNK_CTRL, 1);
        @(negedge clk);
        chk(payloadKind, 1);
        apb(1, `REG_CHUNK_KIND, 32'h0000_0100);
        apb(0, `REG_STATUS, 0);
        chk(rd[1:0], 2'h1);
        apb(1, `REG_CHUNK_KIND, 32'h0000_0001);
        apb(0, `REG_CHUNK_KIND, 0);
        chk(rd[8:0], 9'h001);
        apb(0, `REG_STATUS, 0);
        chk(rd[1:0], 2'h1);
        frames(3);
        apb(0, `REG_FRAME_TALLY, 0);
        chk(rd, 3);
        slow <= 1'b1;
        send(32'hA5A5_0001, 1'b0);
        send(32'h5A5A_0002, 1'b1);
        for (int i = 0; i < 100 && host_sink_i.got.size() < 4; i++) @(posedge clk);
        for (int i = 0; i < 4; i++) chk(host_sink_i.got[i], ex[i]);
        chk(host_sink_i.got[3].data + 32'h1, 32'h3);
    endtask : t_chunk
    task automatic t_off;
        apb(1, `REG_CHUNK_CTRL, 0);
        @(negedge clk);
        chk(payloadKind, 0);
        apb(0, `REG_STATUS, 0);
        chk(rd[1:0], 2'h0);
    endtask : t_off
    task automatic t_clear;
        apb(1, `REG_CLEAR_CMD, 1);
        inputLineOne <= 1'b1;
        inputLineTwo <= 1'b1;
        repeat (6) @(posedge clk);
        apb(0, `REG_FRAME_TALLY, 0);
        chk(rd, 3);
        for (int o = 1; o < 4; o++) begin
            inputLineOne <= 1'b0;
            inputLineTwo <= 1'b0;
            frames(2);
            apb(1, `REG_COUNTER_CTRL, 32'h0000_0110);
            apb(1, `REG_COUNTER_CTRL, 32'h0000_0110 | o);
            if (o == 1) begin
                apb(1, `REG_CLEAR_CMD, 1);
            end else if (o == 2) begin
                inputLineOne <= 1'b1;
            end else begin
                inputLineTwo <= 1'b1;
            end
            repeat (6) @(posedge clk);
            apb(0, `REG_FRAME_TALLY, 0);
            chk(rd, 0);
        end
    endtask : t_clear
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_defaults;
        t_chunk;
        t_off;
        t_clear;
        conclude;
    end
    initial begin
        repeat (20000) @(posedge clk);
        nErrors++;
        conclude;
    end
endmodule : frame_tally_chunk_append_test
`default_nettype wire
